// File: rocf_pkg.sv
// regulator output configuration bank: shared constants, field layout, types
// assumes an external serial-bus engine that delivers decoded byte accesses
package rocf_pkg;

  // register offsets
  localparam logic [7:0] ADDR_BB2_VCODE   = 8'h06;
  localparam logic [7:0] ADDR_BB2_CFG     = 8'h07;
  localparam logic [7:0] ADDR_LR1_VCODE   = 8'h08;
  localparam logic [7:0] ADDR_LR1_CFG     = 8'h09;
  localparam logic [7:0] ADDR_LR2_VCODE   = 8'h0a;
  localparam logic [7:0] ADDR_LR2_CFG     = 8'h0b;
  localparam logic [7:0] ADDR_MON_CFG     = 8'h0c;
  localparam logic [7:0] ADDR_AUX_CFG     = 8'h0d;

  // writable bit masks, all other bits read as zero
  localparam logic [7:0] MASK_VCODE       = 8'h3f;
  localparam logic [7:0] MASK_BB2_CFG     = 8'he8;
  localparam logic [7:0] MASK_LR_CFG      = 8'he1;
  localparam logic [7:0] MASK_MON_CFG     = 8'h0f;
  localparam logic [7:0] MASK_AUX_CFG     = 8'hc3;
  localparam logic [7:0] REG_RESET        = 8'h00;

  // field positions
  localparam int         POS_EN_SEL       = 6;
  localparam int         POS_PDSC         = 5;
  localparam int         POS_RAMP_DIS     = 3;
  localparam int         POS_SW_MODE      = 0;
  localparam int         POS_MON_HIZ      = 3;
  localparam int         POS_MON_SEL      = 0;
  localparam int         POS_AUX_DIR      = 6;
  localparam int         POS_AUX_PULL     = 0;

  // enable-source encodings
  localparam logic [1:0] EN_OFF           = 2'h0;
  localparam logic [1:0] EN_ALWAYS        = 2'h1;
  localparam logic [1:0] EN_CTL_LOW       = 2'h2;
  localparam logic [1:0] EN_CTL_HIGH      = 2'h3;

  // aux output direction and pull encodings
  localparam logic [1:0] DIR_UP           = 2'h0;
  localparam logic [1:0] DIR_DOWN         = 2'h1;
  localparam logic [1:0] DIR_FOLLOW       = 2'h2;
  localparam logic [1:0] DIR_INVERT       = 2'h3;
  localparam int         POS_PULL_UP_OK   = 1;
  localparam int         POS_PULL_DN_OK   = 0;

  localparam logic [2:0] MON_DISABLED     = 3'h0;

  // voltage mapping in millivolts
  localparam logic [11:0] BB2_MIN_MV      = 12'd900;
  localparam logic [11:0] LR_MIN_MV       = 12'd550;
  localparam logic [11:0] STEP_MV         = 12'd50;

  // ramp: one code step per interval
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          RAMP_STEP_NS    = 10000;
  localparam int          RAMP_CYC_INT    = RAMP_STEP_NS / CLK_PERIOD_NS;
  localparam logic [15:0] RAMP_CYCLES     = RAMP_CYC_INT[15:0];

  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rocf_wr_req_t;

  function automatic logic rocf_en_decode(input logic [1:0] sel, input logic ctl);
    unique case (sel)
      EN_OFF:      rocf_en_decode = 1'b0;
      EN_ALWAYS:   rocf_en_decode = 1'b1;
      EN_CTL_LOW:  rocf_en_decode = ~ctl;
      EN_CTL_HIGH: rocf_en_decode = ctl;
    endcase
  endfunction : rocf_en_decode

  function automatic logic [11:0] rocf_code_mv(input logic [11:0] base, input logic [5:0] code);
    logic [11:0] prod;
    prod = {6'h00, code} * STEP_MV;
    rocf_code_mv = base + prod;
  endfunction : rocf_code_mv

endpackage : rocf_pkg

// File: rocf_en_sel.sv
// one output's enable-source decode and passive discharge control
// assumes ctl_i is already synchronised to clk_sys_i
`timescale 1ns/100ps
module rocf_en_sel
  import rocf_pkg::*;
(
  input  wire logic       clk_sys_i,  // system clock
  input  wire logic       resetn_i,   // sync reset, active low
  input  wire logic [1:0] sel_i,      // enable source field
  input  wire logic       pdsc_i,     // passive discharge option
  input  wire logic       ctl_i,      // synchronised control input
  output logic            en_o,       // output enabled
  output logic            dsc_o       // discharge switch closed
);
  logic en_d;
  logic dsc_d;

  always_comb begin
    en_d  = rocf_en_decode(sel_i, ctl_i);
    dsc_d = pdsc_i & ~en_d;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      en_o  <= 1'b0;
      dsc_o <= 1'b0;
    end else begin
      en_o  <= en_d;
      dsc_o <= dsc_d;
    end
  end
endmodule : rocf_en_sel

// File: rocf_regs.sv
// configuration bank for buck-boost 2, both linear regulators, monitor and aux output
// assumes a serial-bus engine hands over decoded byte writes and reads
//
// Behaviour
// - buck-boost 2 enable field selects source
// - buck-boost 2 discharge only when off
// - linear regulator enable field selects source
// - linear regulator discharge only when off
// - monitor disabled: pulldown or high impedance
// - aux direction from field and control input
// - aux pull mode gates pull-up and pull-down
`timescale 1ns/100ps
module rocf_regs
  import rocf_pkg::*;
(
  input  wire logic         clk_sys_i,           // system clock
  input  wire logic         resetn_i,            // sync reset, active low
  input  wire rocf_wr_req_t wr_req_i,            // register write
  input  wire logic         rd_en_i,             // register read strobe
  input  wire logic [7:0]   rd_addr_i,           // register read address
  output logic [7:0]        rd_data_o,           // read data
  output logic              rd_valid_o,          // read data valid
  input  wire logic         aux_control_i,       // asynchronous control input
  output logic              bb2_en_o,            // buck-boost 2 enabled
  output logic              bb2_dsc_o,           // buck-boost 2 discharge
  output logic [11:0]       bb2_target_mv_o,     // buck-boost 2 target
  output logic              linreg1_en_o,        // regulator 1 enabled
  output logic              linreg1_dsc_o,       // regulator 1 discharge
  output logic              linreg1_sw_mode_o,   // regulator 1 load-switch mode
  output logic [11:0]       linreg1_mv_o,        // regulator 1 target
  output logic              linreg2_en_o,        // regulator 2 enabled
  output logic              linreg2_dsc_o,       // regulator 2 discharge
  output logic              linreg2_sw_mode_o,   // regulator 2 load-switch mode
  output logic [11:0]       linreg2_mv_o,        // regulator 2 target
  output logic [2:0]        monitor_sel_o,       // monitor source, 0 = off
  output logic              monitor_pulldown_o,  // monitor pulldown active
  output logic              monitor_highz_o,     // monitor high impedance
  output logic              aux_pullup_en_o,     // aux output pull-up drive
  output logic              aux_pulldown_en_o    // aux output pull-down drive
);
  logic [7:0] bb2_v_q, bb2_cfg_q, lr1_v_q, lr1_cfg_q, lr2_v_q, lr2_cfg_q, mon_q, aux_q;
  logic [7:0] bb2_v_d, bb2_cfg_d, lr1_v_d, lr1_cfg_d, lr2_v_d, lr2_cfg_d, mon_d, aux_d;
  logic [7:0] rd_data_d;
  logic       ctl_s1_q, ctl_s2_q;
  logic [5:0] bb2_tgt_q, bb2_tgt_d;
  logic [15:0] ramp_cnt_q, ramp_cnt_d;
  logic [11:0] bb2_mv_d, lr1_mv_d, lr2_mv_d;
  logic       mon_pd_d, mon_hz_d, aux_up_dir, aux_pu_d, aux_pd_d;

  // register writes, reserved bits forced to zero
  always_comb begin
    bb2_v_d   = bb2_v_q;
    bb2_cfg_d = bb2_cfg_q;
    lr1_v_d   = lr1_v_q;
    lr1_cfg_d = lr1_cfg_q;
    lr2_v_d   = lr2_v_q;
    lr2_cfg_d = lr2_cfg_q;
    mon_d     = mon_q;
    aux_d     = aux_q;
    if (wr_req_i.wr_en) begin
      unique case (wr_req_i.addr)
        ADDR_BB2_VCODE: bb2_v_d   = wr_req_i.wdata & MASK_VCODE;
        ADDR_BB2_CFG:   bb2_cfg_d = wr_req_i.wdata & MASK_BB2_CFG;
        ADDR_LR1_VCODE: lr1_v_d   = wr_req_i.wdata & MASK_VCODE;
        ADDR_LR1_CFG:   lr1_cfg_d = wr_req_i.wdata & MASK_LR_CFG;
        ADDR_LR2_VCODE: lr2_v_d   = wr_req_i.wdata & MASK_VCODE;
        ADDR_LR2_CFG:   lr2_cfg_d = wr_req_i.wdata & MASK_LR_CFG;
        ADDR_MON_CFG:   mon_d     = wr_req_i.wdata & MASK_MON_CFG;
        ADDR_AUX_CFG:   aux_d     = wr_req_i.wdata & MASK_AUX_CFG;
        default:        ;
      endcase
    end
    rd_data_d = 8'h00;
    unique case (rd_addr_i)
      ADDR_BB2_VCODE: rd_data_d = bb2_v_q;
      ADDR_BB2_CFG:   rd_data_d = bb2_cfg_q;
      ADDR_LR1_VCODE: rd_data_d = lr1_v_q;
      ADDR_LR1_CFG:   rd_data_d = lr1_cfg_q;
      ADDR_LR2_VCODE: rd_data_d = lr2_v_q;
      ADDR_LR2_CFG:   rd_data_d = lr2_cfg_q;
      ADDR_MON_CFG:   rd_data_d = mon_q;
      ADDR_AUX_CFG:   rd_data_d = aux_q;
      default:        rd_data_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      bb2_v_q    <= REG_RESET;
      bb2_cfg_q  <= REG_RESET;
      lr1_v_q    <= REG_RESET;
      lr1_cfg_q  <= REG_RESET;
      lr2_v_q    <= REG_RESET;
      lr2_cfg_q  <= REG_RESET;
      mon_q      <= REG_RESET;
      aux_q      <= REG_RESET;
      rd_data_o  <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      bb2_v_q    <= bb2_v_d;
      bb2_cfg_q  <= bb2_cfg_d;
      lr1_v_q    <= lr1_v_d;
      lr1_cfg_q  <= lr1_cfg_d;
      lr2_v_q    <= lr2_v_d;
      lr2_cfg_q  <= lr2_cfg_d;
      mon_q      <= mon_d;
      aux_q      <= aux_d;
      rd_data_o  <= rd_en_i ? rd_data_d : 8'h00;
      rd_valid_o <= rd_en_i;
    end
  end

  // control input synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ctl_s1_q <= 1'b0;
      ctl_s2_q <= 1'b0;
    end else begin
      ctl_s1_q <= aux_control_i;
      ctl_s2_q <= ctl_s1_q;
    end
  end

  rocf_en_sel u_bb2_en (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sel_i     (bb2_cfg_q[POS_EN_SEL +: 2]),
    .pdsc_i    (bb2_cfg_q[POS_PDSC]),
    .ctl_i     (ctl_s2_q),
    .en_o      (bb2_en_o),
    .dsc_o     (bb2_dsc_o)
  );

  rocf_en_sel u_lr1_en (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sel_i     (lr1_cfg_q[POS_EN_SEL +: 2]),
    .pdsc_i    (lr1_cfg_q[POS_PDSC]),
    .ctl_i     (ctl_s2_q),
    .en_o      (linreg1_en_o),
    .dsc_o     (linreg1_dsc_o)
  );

  rocf_en_sel u_lr2_en (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .sel_i     (lr2_cfg_q[POS_EN_SEL +: 2]),
    .pdsc_i    (lr2_cfg_q[POS_PDSC]),
    .ctl_i     (ctl_s2_q),
    .en_o      (linreg2_en_o),
    .dsc_o     (linreg2_dsc_o)
  );

  // ramped target, monitor and aux output next values
  always_comb begin
    bb2_tgt_d  = bb2_tgt_q;
    ramp_cnt_d = 16'h0000;
    if (bb2_cfg_q[POS_RAMP_DIS]) begin
      bb2_tgt_d = bb2_v_q[5:0];
    end else if (bb2_tgt_q != bb2_v_q[5:0]) begin
      if (ramp_cnt_q >= RAMP_CYCLES - 16'h0001) begin
        bb2_tgt_d = (bb2_tgt_q < bb2_v_q[5:0]) ? bb2_tgt_q + 6'h01 : bb2_tgt_q - 6'h01;
      end else begin
        ramp_cnt_d = ramp_cnt_q + 16'h0001;
      end
    end
    bb2_mv_d = rocf_code_mv(BB2_MIN_MV, bb2_tgt_d);
    lr1_mv_d = rocf_code_mv(LR_MIN_MV, lr1_v_q[5:0]);
    lr2_mv_d = rocf_code_mv(LR_MIN_MV, lr2_v_q[5:0]);
    mon_pd_d = (mon_q[POS_MON_SEL +: 3] == MON_DISABLED) & ~mon_q[POS_MON_HIZ];
    mon_hz_d = (mon_q[POS_MON_SEL +: 3] == MON_DISABLED) & mon_q[POS_MON_HIZ];
    unique case (aux_q[POS_AUX_DIR +: 2])
      DIR_UP:     aux_up_dir = 1'b1;
      DIR_DOWN:   aux_up_dir = 1'b0;
      DIR_FOLLOW: aux_up_dir = ctl_s2_q;
      DIR_INVERT: aux_up_dir = ~ctl_s2_q;
    endcase
    aux_pu_d = aux_up_dir & aux_q[POS_AUX_PULL + POS_PULL_UP_OK];
    aux_pd_d = ~aux_up_dir & aux_q[POS_AUX_PULL + POS_PULL_DN_OK];
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      bb2_tgt_q          <= 6'h00;
      ramp_cnt_q         <= 16'h0000;
      bb2_target_mv_o    <= BB2_MIN_MV;
      linreg1_mv_o       <= LR_MIN_MV;
      linreg2_mv_o       <= LR_MIN_MV;
      linreg1_sw_mode_o  <= 1'b0;
      linreg2_sw_mode_o  <= 1'b0;
      monitor_sel_o      <= MON_DISABLED;
      monitor_pulldown_o <= 1'b1;
      monitor_highz_o    <= 1'b0;
      aux_pullup_en_o    <= 1'b0;
      aux_pulldown_en_o  <= 1'b0;
    end else begin
      bb2_tgt_q          <= bb2_tgt_d;
      ramp_cnt_q         <= ramp_cnt_d;
      bb2_target_mv_o    <= bb2_mv_d;
      linreg1_mv_o       <= lr1_mv_d;
      linreg2_mv_o       <= lr2_mv_d;
      linreg1_sw_mode_o  <= lr1_cfg_q[POS_SW_MODE];
      linreg2_sw_mode_o  <= lr2_cfg_q[POS_SW_MODE];
      monitor_sel_o      <= mon_q[POS_MON_SEL +: 3];
      monitor_pulldown_o <= mon_pd_d;
      monitor_highz_o    <= mon_hz_d;
      aux_pullup_en_o    <= aux_pu_d;
      aux_pulldown_en_o  <= aux_pd_d;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_ctl_rise_high_sel;
    $rose(aux_control_i) && bb2_cfg_q[POS_EN_SEL +: 2] == EN_CTL_HIGH
      ##1 (aux_control_i && bb2_cfg_q[POS_EN_SEL +: 2] == EN_CTL_HIGH) [*2];
  endsequence

  sequence s_enable_follows;
    !bb2_en_o ##1 bb2_en_o;
  endsequence

  AST_BB2_DECODE: assert property ($past(resetn_i) |->
    bb2_en_o == (($past(bb2_cfg_q[7:6]) == EN_ALWAYS) ||
                 ($past(bb2_cfg_q[7:6]) == EN_CTL_LOW && !$past(ctl_s2_q)) ||
                 ($past(bb2_cfg_q[7:6]) == EN_CTL_HIGH && $past(ctl_s2_q))))
    else $error("buck-boost 2 enable decode wrong");
  AST_BB2_DSC: assert property ($past(resetn_i) |->
    bb2_dsc_o == ($past(bb2_cfg_q[POS_PDSC]) && !bb2_en_o))
    else $error("buck-boost 2 discharge wrong");
  AST_RAMP_IMMEDIATE: assert property (bb2_cfg_q[POS_RAMP_DIS] |=>
    bb2_tgt_q == $past(bb2_v_q[5:0]))
    else $error("ramp disabled but target not applied");
  AST_RAMP_STEP: assert property (!$past(bb2_cfg_q[POS_RAMP_DIS]) && $past(resetn_i) |->
    (bb2_tgt_q - $past(bb2_tgt_q)) inside {6'h00, 6'h01, 6'h3f})
    else $error("ramp moved more than one code");
  AST_LR2_DSC: assert property ($past(resetn_i) |->
    linreg2_dsc_o == ($past(lr2_cfg_q[POS_PDSC]) && !linreg2_en_o))
    else $error("regulator 2 discharge wrong");
  AST_LR1_DECODE: assert property ($past(resetn_i) |->
    linreg1_en_o == (($past(lr1_cfg_q[7:6]) == EN_ALWAYS) ||
                     ($past(lr1_cfg_q[7:6]) == EN_CTL_LOW && !$past(ctl_s2_q)) ||
                     ($past(lr1_cfg_q[7:6]) == EN_CTL_HIGH && $past(ctl_s2_q))))
    else $error("regulator 1 enable decode wrong");
  AST_MON_OFF: assert property (mon_q == 8'h08 |=>
    monitor_highz_o && !monitor_pulldown_o && monitor_sel_o == MON_DISABLED)
    else $error("monitor off state wrong");
  AST_AUX_FIXED_UP: assert property (aux_q == 8'h03 |=>
    aux_pullup_en_o && !aux_pulldown_en_o)
    else $error("aux fixed pull-up wrong");
  AST_AUX_PULL_OFF: assert property (aux_q[1:0] == 2'h0 |=>
    !aux_pullup_en_o && !aux_pulldown_en_o)
    else $error("aux driver not disabled");
  AST_VCODE_UPPER: assert property (wr_req_i.wr_en && wr_req_i.addr == ADDR_LR1_VCODE |=>
    lr1_v_q[7:6] == 2'h0 ##1 linreg1_mv_o == LR_MIN_MV + {6'h00, lr1_v_q[5:0]} * STEP_MV)
    else $error("voltage code mapping wrong");
  AST_SYNC_LATENCY: assert property (s_ctl_rise_high_sel |-> s_enable_follows)
    else $error("control input latency wrong");
endmodule : rocf_regs

// File: rocf_host_model.sv
// host side of the bank: single-byte register writes and reads
// assumes requests are taken at the rising edge of clk_sys_i
`timescale 1ns/100ps
module rocf_host_model
  import rocf_pkg::*;
(
  input  wire logic   clk_sys_i,  // system clock
  output rocf_wr_req_t wr_req_o,  // write request
  output logic        rd_en_o,    // read strobe
  output logic [7:0]  rd_addr_o   // read address
);
  initial begin
    wr_req_o  = '0;
    rd_en_o   = 1'b0;
    rd_addr_o = 8'h00;
  end
  // released address and data show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_req_o <= '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge clk_sys_i);
    wr_req_o <= '{wr_en: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    rd_en_o   <= 1'b1;
    rd_addr_o <= a;
    @(posedge clk_sys_i);
    rd_en_o   <= 1'b0;
    rd_addr_o <= ~a;
  endtask : rd
endmodule : rocf_host_model

// File: rocf_regs_tb.sv
// self-checking bench for the regulator output configuration bank
// assumes the host model drives the register port, bench drives control
`timescale 1ns/100ps
module rocf_regs_tb;
  import rocf_pkg::*;
  logic clk_sys_i, resetn_i, aux_control_i, rd_en, rd_valid;
  rocf_wr_req_t wr_req;
  logic [7:0] rd_addr, rd_data, d;
  logic bb2_en, bb2_dsc, lr1_en, lr1_dsc, lr1_sw, lr2_en, lr2_dsc, lr2_sw;
  logic mon_pd, mon_hz, aux_up, aux_dn, en, up;
  logic [11:0] bb2_mv, lr1_mv, lr2_mv;
  logic [2:0] mon_sel;
  logic [5:0] code;
  logic [7:0] exp_q[$];
  int n_mismatch, check_count;

  rocf_host_model host (.clk_sys_i(clk_sys_i), .wr_req_o(wr_req), .rd_en_o(rd_en),
                        .rd_addr_o(rd_addr));
  rocf_regs DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .wr_req_i(wr_req),
    .rd_en_i(rd_en), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .aux_control_i(aux_control_i), .bb2_en_o(bb2_en), .bb2_dsc_o(bb2_dsc),
    .bb2_target_mv_o(bb2_mv), .linreg1_en_o(lr1_en), .linreg1_dsc_o(lr1_dsc),
    .linreg1_sw_mode_o(lr1_sw), .linreg1_mv_o(lr1_mv), .linreg2_en_o(lr2_en),
    .linreg2_dsc_o(lr2_dsc), .linreg2_sw_mode_o(lr2_sw), .linreg2_mv_o(lr2_mv),
    .monitor_sel_o(mon_sel), .monitor_pulldown_o(mon_pd), .monitor_highz_o(mon_hz),
    .aux_pullup_en_o(aux_up), .aux_pulldown_en_o(aux_dn));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic bad(string what, logic [11:0] e, logic [11:0] s);
    n_mismatch++;
    $display("BAD %s expected %h seen %h", what, e, s);
  endtask : bad
  task automatic cmp_rd(string what, logic [7:0] e, logic [7:0] s);
    check_count++;
    if (s !== e) bad(what, {4'h0, e}, {4'h0, s});
  endtask : cmp_rd
  task automatic cmp_mv(string what, logic [11:0] e, logic [11:0] s);
    check_count++;
    if (s !== e) bad(what, e, s);
  endtask : cmp_mv
  task automatic cmp_bit(string what, logic e, logic s);
    check_count++;
    if (s !== e) bad(what, {11'h0, e}, {11'h0, s});
  endtask : cmp_bit
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : wait_cyc
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rd_chk
  task automatic wait_mv(logic [11:0] e, int lim);
    int k = 0;
    while (bb2_mv !== e && k < lim) begin
      wait_cyc(1);
      k++;
    end
    cmp_mv("bb2_ramp", e, bb2_mv);
    if (bb2_mv !== e) test_done();
  endtask : wait_mv
  function automatic logic [7:0] msk(logic [7:0] a);
    case (a)
      ADDR_BB2_VCODE, ADDR_LR1_VCODE, ADDR_LR2_VCODE: msk = MASK_VCODE;
      ADDR_BB2_CFG: msk = MASK_BB2_CFG;
      ADDR_LR1_CFG, ADDR_LR2_CFG: msk = MASK_LR_CFG;
      ADDR_MON_CFG: msk = MASK_MON_CFG;
      ADDR_AUX_CFG: msk = MASK_AUX_CFG;
      default: msk = 8'h00;
    endcase
  endfunction : msk

  // read results are matched against the oldest note
  always @(posedge clk_sys_i) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) bad("rd_extra", 12'h000, {4'h0, rd_data});
      else cmp_rd("rd_data", exp_q.pop_front(), rd_data);
    end
  end

  initial begin
    resetn_i      = 1'b0;
    aux_control_i = 1'b0;
    void'($urandom(32'hd355));
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    #1;
    cmp_bit("mon_pd_rst", 1'b1, mon_pd);
    cmp_mv("bb2_rst", BB2_MIN_MV, bb2_mv);
    cmp_mv("lr1_rst", LR_MIN_MV, lr1_mv);
    for (int i = 0; i < 10; i++) rd_chk(8'h05 + i[7:0], REG_RESET);
    for (int i = 0; i < 20; i++) begin
      d = i[0] ? 8'hff : 8'($urandom);
      host.wr(8'h05 + i[7:1], d);
      rd_chk(8'h05 + i[7:1], d & msk(8'h05 + i[7:1]));
    end
    $display("test regs done");
    for (int s = 0; s < 4; s++) for (int p = 0; p < 2; p++) for (int c = 0; c < 2; c++) begin
      d = {s[1:0], p[0], 5'h00};
      host.wr(ADDR_BB2_CFG, d | 8'h08);
      host.wr(ADDR_LR1_CFG, d | {7'h00, c[0]});
      host.wr(ADDR_LR2_CFG, d | {7'h00, ~c[0]});
      aux_control_i <= c[0];
      wait_cyc(6);
      en = (s == 1) || (s == 2 && c == 0) || (s == 3 && c == 1);
      cmp_bit("bb2_en", en, bb2_en);
      cmp_bit("bb2_dsc", p[0] & ~en, bb2_dsc);
      cmp_bit("lr1_en", en, lr1_en);
      cmp_bit("lr1_dsc", p[0] & ~en, lr1_dsc);
      cmp_bit("lr2_en", en, lr2_en);
      cmp_bit("lr2_dsc", p[0] & ~en, lr2_dsc);
      cmp_bit("lr1_sw", c[0], lr1_sw);
      cmp_bit("lr2_sw", ~c[0], lr2_sw);
    end
    $display("test enables done");
    for (int i = 0; i < 16; i++) begin
      host.wr(ADDR_MON_CFG, {4'h0, i[3:0]});
      wait_cyc(3);
      cmp_mv("mon_sel", {9'h000, i[2:0]}, {9'h000, mon_sel});
      cmp_bit("mon_pd", i[2:0] == 3'h0 && !i[3], mon_pd);
      cmp_bit("mon_hz", i[2:0] == 3'h0 && i[3], mon_hz);
    end
    $display("test monitor done");
    for (int i = 0; i < 32; i++) begin
      host.wr(ADDR_AUX_CFG, {i[3:2], 4'h0, i[1:0]});
      aux_control_i <= i[4];
      wait_cyc(6);
      up = (i[3:2] == DIR_UP) || (i[3:2] == DIR_FOLLOW && i[4]) ||
           (i[3:2] == DIR_INVERT && !i[4]);
      cmp_bit("aux_up", up & i[1], aux_up);
      cmp_bit("aux_dn", ~up & i[0], aux_dn);
    end
    $display("test aux done");
    code = 6'($urandom);
    host.wr(ADDR_LR1_VCODE, {2'b11, code});
    host.wr(ADDR_LR2_VCODE, 8'hff);
    wait_cyc(3);
    cmp_mv("lr1_mv", LR_MIN_MV + {6'h00, code} * STEP_MV, lr1_mv);
    cmp_mv("lr2_mv", LR_MIN_MV + 12'd63 * STEP_MV, lr2_mv);
    host.wr(ADDR_BB2_CFG, 8'h08);
    host.wr(ADDR_BB2_VCODE, 8'h03);
    wait_cyc(3);
    cmp_mv("bb2_now", BB2_MIN_MV + 12'd3 * STEP_MV, bb2_mv);
    host.wr(ADDR_BB2_CFG, 8'h00);
    host.wr(ADDR_BB2_VCODE, 8'h05);
    wait_cyc(100);
    cmp_mv("bb2_hold", BB2_MIN_MV + 12'd3 * STEP_MV, bb2_mv);
    wait_mv(BB2_MIN_MV + 12'd4 * STEP_MV, 1100);
    wait_cyc(500);
    cmp_mv("bb2_step", BB2_MIN_MV + 12'd4 * STEP_MV, bb2_mv);
    wait_mv(BB2_MIN_MV + 12'd5 * STEP_MV, 1100);
    $display("test voltage done");
    wait_cyc(4);
    if (exp_q.size() != 0) bad("rd_missing", 12'h000, 12'(exp_q.size()));
    test_done();
  end
endmodule : rocf_regs_tb
